// ==== verilog/snrd_consts.vh ====
/*
 * constants for the serial nand multi-lane fast read engine: opcodes,
 * field widths, pre-data clock counts per opcode and read mode, buffer size.
 * assumes inclusion by bare name from the design and simulation files.
 */
`ifndef SNRD_CONSTS_VH
`define SNRD_CONSTS_VH

// ****************************************************************
// opcodes
// ****************************************************************
`define SNRD_OP_QOUT4      8'h6C
`define SNRD_OP_DIO        8'hBB
`define SNRD_OP_DIO4       8'hBC
`define SNRD_OP_QIO        8'hEB
`define SNRD_OP_QIO4       8'hEC

// ****************************************************************
// geometry and field sizes
// ****************************************************************
`define SNRD_CMD_BITS      4'h8
`define SNRD_COL_BITS      5'h10
`define SNRD_BUF_BYTES     2176
`define SNRD_COL_W         12
`define SNRD_PAGE_W        17

// ****************************************************************
// address plus dummy clocks before data, buffer mode (b1) / sequential (b0)
// ****************************************************************
`define SNRD_PRE_QOUT4_B1  6'h28
`define SNRD_PRE_QOUT4_B0  6'h28
`define SNRD_PRE_DIO_B1    6'h0C
`define SNRD_PRE_DIO_B0    6'h10
`define SNRD_PRE_DIO4_B1   6'h10
`define SNRD_PRE_DIO4_B0   6'h14
`define SNRD_PRE_QIO_B1    6'h08
`define SNRD_PRE_QIO_B0    6'h0A
`define SNRD_PRE_QIO4_B1   6'h0A
`define SNRD_PRE_QIO4_B0   6'h0C

`endif

// ==== verilog/snrd_sync.v ====
/*
 * two flip-flop synchroniser for a group of asynchronous levels.
 * assumes each bit is an independent level; no bus coherency is kept.
 */
`timescale 1ns/1ns

module snrd_sync #(
   parameter W = 6
) (
   input  wire         clk,    // core clock
   input  wire         srst,   // synchronous reset, high
   input  wire [W-1:0] d,      // asynchronous levels
   output reg  [W-1:0] q       // synchronised levels
);

   reg [W-1:0] meta_ff;        // first stage, read only by q

   // ****************************************************************
   // two stages; first stage feeds nothing but the second
   // ****************************************************************
   always @(posedge clk) begin
      if (srst) begin
         meta_ff <= {W{1'b0}};
         q       <= {W{1'b0}};
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end

endmodule // snrd_sync

// ==== verilog/snrd_top.v ====
/*
 * serial nand fast read engine for opcodes 6Ch, BBh, BCh, EBh, ECh.
 * decodes the opcode, takes the column over 1/2/4 lanes, counts dummy
 * clocks and streams buffer bytes out over 2 or 4 lanes.
 * assumes: spi pins are asynchronous and sampled at 100 MHz (sck much
 * slower); the data buffer answers buf_rd_data one clk after the address;
 * buf_mode, wp_en and page_sel are quasi-static levels on clk.
 */
// Behaviour
// - opcode 6Ch returns data on all four lanes at once.
// - in buffer mode output starts at the host column and runs to the last buffer byte.
// - in buffer mode the lanes float once the last byte has been shifted out.
// - in sequential mode the column is ignored and output starts at byte zero.
// - in sequential mode the end of the buffer rolls on to byte zero of the next page.
// - dual i/o reads take column and dummy two bits a clock and return data on lanes zero and one.
// - quad i/o reads take column and dummy on four lanes and return data on four lanes.
// - with write protect enabled, 6Ch, EBh and ECh are not executed.
// - each byte leaves msb first, changing on the falling sck edge.
// - the read pointer advances by one after each byte with no new command.
`timescale 1ns/1ns
`include "snrd_consts.vh"

module snrd_top #(
   parameter BUF_BYTES = `SNRD_BUF_BYTES,
   parameter COL_W     = `SNRD_COL_W,
   parameter PAGE_W    = `SNRD_PAGE_W
) (
   input  wire              clk,          // core clock, 100 MHz
   input  wire              srst,         // synchronous reset, high
   input  wire              spi_sck,      // serial clock from host
   input  wire              spi_cs_n,     // chip select, low active
   input  wire [3:0]        io_in,        // lane levels seen on the pins
   output reg  [3:0]        io_out,       // lane drive values
   output reg  [3:0]        io_oe,        // lane drive enables, high drives
   input  wire              buf_mode,     // read mode select, 1 buffer 0 sequential
   input  wire              wp_en,        // write protect enable
   input  wire [PAGE_W-1:0] page_sel,     // page now held in the buffer
   output reg  [COL_W-1:0]  buf_rd_col,   // buffer read column
   output reg  [PAGE_W-1:0] buf_rd_page,  // page of the byte being fetched
   input  wire [7:0]        buf_rd_data,  // buffer data, one clk after address
   output reg               busy          // a read is in its data phase
);

   // ****************************************************************
   // states
   // ****************************************************************
   localparam ST_IDLE = 3'h0;
   localparam ST_CMD  = 3'h1;
   localparam ST_PRE  = 3'h2;
   localparam ST_DATA = 3'h3;
   localparam ST_DONE = 3'h4;

   // ****************************************************************
   // decode helpers
   // ****************************************************************
   function op_known;
      input [7:0] op;
      begin
         op_known = (op == `SNRD_OP_QOUT4) || (op == `SNRD_OP_DIO) || (op == `SNRD_OP_DIO4) ||
                    (op == `SNRD_OP_QIO) || (op == `SNRD_OP_QIO4);
      end
   endfunction

   function op_quad;
      input [7:0] op;
      begin
         op_quad = (op == `SNRD_OP_QOUT4) || (op == `SNRD_OP_QIO) || (op == `SNRD_OP_QIO4);
      end
   endfunction

   // lanes carrying column and dummy bits
   function [2:0] addr_lanes;
      input [7:0] op;
      begin
         case (op)
            `SNRD_OP_DIO, `SNRD_OP_DIO4: addr_lanes = 3'h2;
            `SNRD_OP_QIO, `SNRD_OP_QIO4: addr_lanes = 3'h4;
            default: addr_lanes = 3'h1;
         endcase
      end
   endfunction

   function [5:0] pre_clks;
      input [7:0] op;
      input       bm;
      begin
         case (op)
            `SNRD_OP_QOUT4: pre_clks = bm ? `SNRD_PRE_QOUT4_B1 : `SNRD_PRE_QOUT4_B0;
            `SNRD_OP_DIO:   pre_clks = bm ? `SNRD_PRE_DIO_B1   : `SNRD_PRE_DIO_B0;
            `SNRD_OP_DIO4:  pre_clks = bm ? `SNRD_PRE_DIO4_B1  : `SNRD_PRE_DIO4_B0;
            `SNRD_OP_QIO:   pre_clks = bm ? `SNRD_PRE_QIO_B1   : `SNRD_PRE_QIO_B0;
            default:        pre_clks = bm ? `SNRD_PRE_QIO4_B1  : `SNRD_PRE_QIO4_B0;
         endcase
      end
   endfunction

   // shift lane bits into the column register, lane with highest index is msb
   function [15:0] shift_in;
      input [15:0] sr;
      input [3:0]  io;
      input [2:0]  lanes;
      begin
         case (lanes)
            3'h2:    shift_in = {sr[13:0], io[1:0]};
            3'h4:    shift_in = {sr[11:0], io[3:0]};
            default: shift_in = {sr[14:0], io[0]};
         endcase
      end
   endfunction

   // top bits of a byte placed on the lanes
   function [3:0] chunk;
      input [7:0] b;
      input       quad;
      begin
         chunk = quad ? b[7:4] : {2'h0, b[7:6]};
      end
   endfunction

   function [7:0] shift_out;
      input [7:0] b;
      input       quad;
      begin
         shift_out = quad ? {b[3:0], 4'h0} : {b[5:0], 2'h0};
      end
   endfunction

   // ****************************************************************
   // pin sampling and sck edge detection
   // ****************************************************************
   wire [5:0] pin_s;
   wire       sck_s  = pin_s[5];
   wire       cs_n_s = pin_s[4];
   wire [3:0] io_s   = pin_s[3:0];
   reg        sck_d_ff;

   snrd_sync #(.W(6)) u_sync (
      .clk  (clk),
      .srst (srst),
      .d    ({spi_sck, spi_cs_n, io_in}),
      .q    (pin_s)
   );

   wire sck_rise = sck_s & ~sck_d_ff;
   wire sck_fall = ~sck_s & sck_d_ff;

   // ****************************************************************
   // engine state
   // ****************************************************************
   reg [2:0]  state_ff;
   reg [7:0]  op_ff;
   reg [5:0]  cnt_ff;             // clocks seen in the current phase
   reg [15:0] col_sr_ff;          // incoming column bits
   reg [7:0]  byte_sr_ff;         // byte being shifted out
   reg [3:0]  bits_left_ff;       // bits of byte_sr_ff still to send
   reg [7:0]  fetch_ff;           // prefetched next byte
   reg [1:0]  pend_ff;            // fetch pipeline
   reg        end_ff;             // last buffer byte already loaded

   wire [7:0] nxt_op    = {op_ff[6:0], io_s[0]};
   wire       quad_data = op_quad(op_ff);
   wire [2:0] alanes    = addr_lanes(op_ff);
   wire       last_col  = (buf_rd_col == BUF_BYTES[COL_W-1:0] - 1'b1);

   // ****************************************************************
   // prefetch: capture buffer data two clks after a new address settles
   // ****************************************************************
   always @(posedge clk) begin
      if (srst) begin
         pend_ff  <= 2'h0;
         fetch_ff <= 8'h00;
      end else begin
         pend_ff <= {pend_ff[0], 1'b0};
         if (pend_ff[1])
            fetch_ff <= buf_rd_data;
         if (state_ff == ST_PRE && sck_rise && cnt_ff == pre_clks(op_ff, buf_mode) - 1'b1)
            pend_ff[0] <= 1'b1;
         else if (state_ff == ST_DATA && sck_fall && bits_left_ff == 4'h0 && !end_ff)
            pend_ff[0] <= 1'b1;
      end
   end

   // ****************************************************************
   // main sequencer; chip select high aborts any phase at once
   // ****************************************************************
   always @(posedge clk) begin
      if (srst) begin
         sck_d_ff     <= 1'b0;
         state_ff     <= ST_IDLE;
         op_ff        <= 8'h00;
         cnt_ff       <= 6'h00;
         col_sr_ff    <= 16'h0000;
         byte_sr_ff   <= 8'h00;
         bits_left_ff <= 4'h0;
         end_ff       <= 1'b0;
         io_out       <= 4'h0;
         io_oe        <= 4'h0;
         buf_rd_col   <= {COL_W{1'b0}};
         buf_rd_page  <= {PAGE_W{1'b0}};
         busy         <= 1'b0;
      end else begin
         sck_d_ff <= sck_s;
         if (cs_n_s) begin
            state_ff <= ST_IDLE;
            io_oe    <= 4'h0;
            busy     <= 1'b0;
         end else begin
            case (state_ff)
               ST_IDLE: begin
                  state_ff <= ST_CMD;
                  cnt_ff   <= 6'h00;
                  end_ff   <= 1'b0;
                  if (sck_rise) begin                      // first opcode bit on this edge
                     op_ff  <= nxt_op;
                     cnt_ff <= 6'h01;
                  end
               end
               ST_CMD: begin
                  if (sck_rise) begin
                     op_ff  <= nxt_op;
                     cnt_ff <= cnt_ff + 6'h01;
                     if (cnt_ff == {2'h0, `SNRD_CMD_BITS} - 6'h01) begin
                        cnt_ff <= 6'h00;
                        // unknown or write protected opcodes sit out the frame
                        if (!op_known(nxt_op) || (wp_en && op_quad(nxt_op)))
                           state_ff <= ST_DONE;
                        else
                           state_ff <= ST_PRE;
                     end
                  end
               end
               ST_PRE: begin
                  if (sck_rise) begin
                     cnt_ff <= cnt_ff + 6'h01;
                     // only the first 16 bits form the column; the rest are dummy
                     if ({3'h0, cnt_ff} * {6'h0, alanes} < {4'h0, `SNRD_COL_BITS})
                        col_sr_ff <= shift_in(col_sr_ff, io_s, alanes);
                     if (cnt_ff == pre_clks(op_ff, buf_mode) - 1'b1) begin
                        state_ff     <= ST_DATA;
                        busy         <= 1'b1;
                        bits_left_ff <= 4'h0;
                        buf_rd_page  <= page_sel;
                        if (buf_mode)
                           buf_rd_col <= col_sr_ff[COL_W-1:0];
                        else
                           buf_rd_col <= {COL_W{1'b0}};
                     end
                  end
               end
               ST_DATA: begin
                  if (sck_fall) begin
                     if (bits_left_ff == 4'h0) begin
                        if (end_ff) begin
                           io_oe    <= 4'h0;
                           state_ff <= ST_DONE;
                           busy     <= 1'b0;
                        end else begin
                           io_out       <= chunk(fetch_ff, quad_data);
                           io_oe        <= quad_data ? 4'hF : 4'h3;
                           byte_sr_ff   <= shift_out(fetch_ff, quad_data);
                           bits_left_ff <= quad_data ? 4'h4 : 4'h6;
                           // advance pointer for the next prefetch
                           if (last_col) begin
                              if (buf_mode)
                                 end_ff <= 1'b1;
                              else begin
                                 buf_rd_col  <= {COL_W{1'b0}};
                                 buf_rd_page <= buf_rd_page + 1'b1;
                              end
                           end else
                              buf_rd_col <= buf_rd_col + 1'b1;
                        end
                     end else begin
                        io_out       <= chunk(byte_sr_ff, quad_data);
                        byte_sr_ff   <= shift_out(byte_sr_ff, quad_data);
                        bits_left_ff <= bits_left_ff - (quad_data ? 4'h4 : 4'h2);
                     end
                  end
               end
               ST_DONE: begin
                  io_oe <= 4'h0;
                  busy  <= 1'b0;
               end
               default: state_ff <= ST_IDLE;
            endcase
         end
      end
   end

endmodule // snrd_top

// ==== sim/snrd_host.sv ====
/* host controller model that frames the five fast reads on the quad lanes.
   assumes the bench resolves the lanes into io_w and feeds back dev_oe. */
`timescale 1ns/1ns
`include "snrd_consts.vh"
module snrd_host (
   output logic       sck,     // serial clock, low between frames
   output logic       cs_n,    // chip select, low active
   output logic [3:0] h_out,   // host lane values
   output logic [3:0] h_oe,    // host lane enables
   input  wire  [3:0] io_w,    // resolved lane levels
   input  wire  [3:0] dev_oe   // device lane enables
);
   logic [7:0] rx  [0:31];    // bytes taken per frame
   logic [3:0] drv [0:31];    // device enables seen per byte
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      h_out = 4'h0;
      h_oe = 4'h0;
   end
   // ****************************************************************
   // one sck period: lanes set in the low phase, sampled on the rise
   // ****************************************************************
   task automatic tick(input logic [3:0] v, input logic [3:0] e, output logic [3:0] s, output logic [3:0] o);
      h_out = v;
      h_oe = e;
      #62 sck = 1'b1;
      s = io_w;
      o = dev_oe;
      #63 sck = 1'b0;
   endtask
   // whole read frame; dummy clocks leave the lanes undriven
   task automatic frame(input logic [7:0] op, input logic [15:0] col, input logic bm, input int nb);
      int ln, dl, pre;
      logic [3:0] s, o;
      logic [15:0] c;
      ln = (op == `SNRD_OP_QOUT4) ? 1 : (op[6] ? 4 : 2);
      dl = (ln == 2) ? 2 : 4;
      case (op)
         `SNRD_OP_QOUT4: pre = bm ? `SNRD_PRE_QOUT4_B1 : `SNRD_PRE_QOUT4_B0;
         `SNRD_OP_DIO:   pre = bm ? `SNRD_PRE_DIO_B1 : `SNRD_PRE_DIO_B0;
         `SNRD_OP_DIO4:  pre = bm ? `SNRD_PRE_DIO4_B1 : `SNRD_PRE_DIO4_B0;
         `SNRD_OP_QIO:   pre = bm ? `SNRD_PRE_QIO_B1 : `SNRD_PRE_QIO_B0;
         default:        pre = bm ? `SNRD_PRE_QIO4_B1 : `SNRD_PRE_QIO4_B0;
      endcase
      c = col;
      cs_n = 1'b0;
      #63;
      for (int i = 7; i >= 0; i--) tick({3'h0, op[i]}, 4'h1, s, o);
      for (int i = 0; i < pre; i++) begin
         if (i < 16 / ln) begin
            tick(4'(c >> (16 - ln)), (4'h1 << ln) - 4'h1, s, o);
            c = c << ln;
         end else
            tick(4'h0, 4'h0, s, o);
      end
      for (int b = 0; b < nb; b++) begin
         rx[b] = 8'h00;
         drv[b] = 4'h0;
         for (int k = 0; k < 8 / dl; k++) begin
            tick(4'h0, 4'h0, s, o);
            rx[b] = (rx[b] << dl) | (s & ((4'h1 << dl) - 4'h1));
            drv[b] = drv[b] | o;
         end
      end
      cs_n = 1'b1;
      #100;
   endtask
endmodule // snrd_host

// ==== sim/snrd_top_props.sv ====
/* assertion checker for the fast read engine, bound into snrd_top.
   assumes the host holds each sck phase for at least four core clocks. */
`timescale 1ns/1ns
module snrd_top_props #(
   parameter BUF_BYTES = 2176,
   parameter COL_W     = 12,
   parameter PAGE_W    = 17
) (
   input wire              clk,          // core clock
   input wire              srst,         // synchronous reset, high
   input wire              spi_sck,      // serial clock pin
   input wire              spi_cs_n,     // chip select pin
   input wire [3:0]        io_in,        // lane levels
   input wire [3:0]        io_out,       // lane drive values
   input wire [3:0]        io_oe,        // lane drive enables
   input wire              buf_mode,     // read mode select
   input wire              wp_en,        // write protect enable
   input wire [PAGE_W-1:0] page_sel,     // page in the buffer
   input wire [COL_W-1:0]  buf_rd_col,   // fetch column
   input wire [PAGE_W-1:0] buf_rd_page,  // fetch page
   input wire [7:0]        buf_rd_data,  // fetched byte
   input wire              busy          // data phase flag
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // ****************************************************************
   // lane drive and pointer rules
   // ****************************************************************
   oe_legal_a: assert property (io_oe == 4'h0 || io_oe == 4'h3 || io_oe == 4'hF)
      else $error("lane enables hold an illegal set");
   wp_block_a: assert property (wp_en |-> io_oe != 4'hF)
      else $error("quad data driven under write protect");
   cs_release_a: assert property ($rose(spi_cs_n) |-> ##[1:6] io_oe == 4'h0)
      else $error("lanes still driven after deselect");
   idle_quiet_a: assert property (spi_cs_n [*8] |-> io_oe == 4'h0)
      else $error("lanes driven while deselected");
   drive_busy_a: assert property (io_oe != 4'h0 |-> busy)
      else $error("lanes driven outside the data phase");
   oe_steady_a: assert property (io_oe != 4'h0 && $past(io_oe) != 4'h0 |-> $stable(io_oe))
      else $error("lane set changed inside a frame");
   out_on_fall_a: assert property (!$stable(io_out) && io_oe != 4'h0 |-> !spi_sck && !$past(spi_sck, 2))
      else $error("output changed away from a falling sck");
   col_step_a: assert property (busy && $past(busy) && buf_rd_col != $past(buf_rd_col)
                                |-> buf_rd_col == $past(buf_rd_col) + 1'b1 || buf_rd_col == {COL_W{1'b0}})
      else $error("fetch column did not step by one");
   page_step_a: assert property (busy && $past(busy) && buf_rd_page != $past(buf_rd_page)
                                 |-> !buf_mode && buf_rd_col == {COL_W{1'b0}}
                                     && buf_rd_page == $past(buf_rd_page) + 1'b1)
      else $error("page advanced outside a sequential wrap");
   seq_start_a: assert property ($rose(busy) && !buf_mode |-> buf_rd_col == {COL_W{1'b0}})
      else $error("sequential read did not start at column zero");
   page_hold_a: assert property (busy && $past(busy) && buf_mode |-> $stable(buf_rd_page))
      else $error("page moved in buffer mode");
endmodule // snrd_top_props
bind snrd_top snrd_top_props #(.BUF_BYTES(BUF_BYTES), .COL_W(COL_W), .PAGE_W(PAGE_W)) chk_u (
   .clk(clk), .srst(srst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .io_in(io_in), .io_out(io_out),
   .io_oe(io_oe), .buf_mode(buf_mode), .wp_en(wp_en), .page_sel(page_sel), .buf_rd_col(buf_rd_col),
   .buf_rd_page(buf_rd_page), .buf_rd_data(buf_rd_data), .busy(busy));

// ==== sim/testbench.sv ====
/* self-checking bench for snrd_top with a 16-byte buffer for short wraps.
   assumes snrd_host as the far side and a one-clock buffer model here. */
`timescale 1ns/1ns
`include "snrd_consts.vh"
module testbench;
   localparam int NB = 16;
   typedef struct packed {logic [7:0] op; logic bm; logic wp; logic [15:0] col; int nb; logic [3:0] m;} snrd_row_t;
   logic        clk = 1'b0, srst = 1'b1, buf_mode = 1'b0, wp_en = 1'b0, tog = 1'b0;
   logic [16:0] page_sel = 17'h00007;
   logic [7:0]  buf_rd_data = 8'h00;
   wire         sck, cs_n, busy;
   wire  [3:0]  h_out, h_oe, io_out, io_oe, io_w;
   wire  [11:0] col;
   wire  [16:0] pg;
   int          bad_count = 0, n_tests = 0;
   // rows: opcode, mode, protect, column, bytes, lanes expected; last opcode must be ignored
   snrd_row_t rows [0:10] = '{
      '{`SNRD_OP_QOUT4, 1'b1, 1'b0, 16'h0003, 4, 4'hF},
      '{`SNRD_OP_DIO,   1'b1, 1'b0, 16'h0005, 3, 4'h3},
      '{`SNRD_OP_DIO4,  1'b0, 1'b0, 16'h0009, 18, 4'h3},
      '{`SNRD_OP_QIO,   1'b1, 1'b0, 16'h000E, 3, 4'hF},
      '{`SNRD_OP_QIO4,  1'b0, 1'b0, 16'hF002, 3, 4'hF},
      '{`SNRD_OP_QOUT4, 1'b0, 1'b0, 16'h0000, 17, 4'hF},
      '{`SNRD_OP_QOUT4, 1'b1, 1'b1, 16'h0001, 2, 4'h0},
      '{`SNRD_OP_QIO,   1'b1, 1'b1, 16'h0001, 2, 4'h0},
      '{`SNRD_OP_QIO4,  1'b0, 1'b1, 16'h0000, 2, 4'h0},
      '{`SNRD_OP_DIO,   1'b1, 1'b1, 16'h0002, 2, 4'h3},
      '{8'h6B,          1'b1, 1'b0, 16'h0001, 2, 4'h0}};
   always #5 clk = ~clk;
   // undriven lanes toggle so a stale level never passes for data
   always @(posedge clk) tog <= ~tog;
   assign io_w = (io_oe & io_out) | (~io_oe & h_oe & h_out) | (~io_oe & ~h_oe & {4{tog}});
   // buffer model: byte depends on page and column, one clock late
   always @(posedge clk) buf_rd_data <= {pg[3:0], col[3:0]} ^ 8'h5A;
   snrd_host host_u (.sck(sck), .cs_n(cs_n), .h_out(h_out), .h_oe(h_oe), .io_w(io_w), .dev_oe(io_oe));
   snrd_top #(.BUF_BYTES(NB)) dut_u (
      .clk(clk), .srst(srst), .spi_sck(sck), .spi_cs_n(cs_n), .io_in(io_w), .io_out(io_out),
      .io_oe(io_oe), .buf_mode(buf_mode), .wp_en(wp_en), .page_sel(page_sel), .buf_rd_col(col),
      .buf_rd_page(pg), .buf_rd_data(buf_rd_data), .busy(busy));
   // ****************************************************************
   // compare and verdict
   // ****************************************************************
   task automatic check_val(input string nm, input logic [16:0] exp, input logic [16:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic end_sim;
      if (bad_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // hang guard; frames are fixed length so this is generous
   initial begin
      #200000;
      check_val("timeout", 17'h0, 17'h1);
      end_sim;
   end
   initial begin
      int c;
      logic fl;
      logic [7:0] e;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      #1;
      check_val("oe_rst", 17'h0, io_oe);
      check_val("busy_rst", 17'h0, busy);
      check_val("col_rst", 17'h0, col);
      check_val("page_rst", 17'h0, pg);
      repeat (6) @(posedge clk);
      foreach (rows[r]) begin
         buf_mode <= rows[r].bm;
         wp_en <= rows[r].wp;
         @(posedge clk);
         // link pins then move between core clock edges, never on one
         #1;
         host_u.frame(rows[r].op, rows[r].col, rows[r].bm, rows[r].nb);
         for (int b = 0; b < rows[r].nb; b++) begin
            c = (rows[r].bm ? int'(rows[r].col[11:0]) : 0) + b;
            fl = rows[r].bm && c >= NB;
            e = {4'(7 + c / NB), 4'(c % NB)} ^ 8'h5A;
            check_val("lanes", fl ? 4'h0 : rows[r].m, host_u.drv[b]);
            if (!fl && rows[r].m != 4'h0)
               check_val("data", e, host_u.rx[b]);
         end
         check_val("oe_end", 17'h0, io_oe);
      end
      // reset inside a sequential data phase while the host keeps clocking
      buf_mode <= 1'b0;
      wp_en <= 1'b0;
      @(posedge clk);
      #1;
      fork
         host_u.frame(`SNRD_OP_DIO4, 16'h0000, 1'b0, 18);
         begin
            repeat (500) @(posedge clk);
            #1;
            check_val("busy_run", 17'h1, busy);
            @(posedge clk);
            srst <= 1'b1;
            repeat (2) @(posedge clk);
            srst <= 1'b0;
            #1;
            check_val("oe_mid", 17'h0, io_oe);
            check_val("busy_mid", 17'h0, busy);
            check_val("col_mid", 17'h0, col);
            check_val("page_mid", 17'h0, pg);
            @(posedge clk);
            #1;
            check_val("oe_mid2", 17'h0, io_oe);
         end
      join
      check_val("oe_cut", 17'h0, io_oe);
      // a clean buffer-mode quad read must follow the cut frame
      buf_mode <= 1'b1;
      @(posedge clk);
      #1;
      host_u.frame(`SNRD_OP_QIO, 16'h0002, 1'b1, 2);
      for (int b = 0; b < 2; b++)
         check_val("data_rec", {4'h7, 4'(2 + b)} ^ 8'h5A, host_u.rx[b]);
      end_sim;
   end
endmodule // testbench
